// File: hdl/ext_irq_pkg.sv
// Purpose: constants for the external interrupt input block
// Assumes: one 125 MHz clock, synchronous active-high reset
// Notes:   register map is local to this block's plain register port
package ext_irq_pkg;

   // ****************************************************************
   // widths
   // ****************************************************************
   localparam int NUM_RISE  = 7;                // rising-edge sources
   localparam int NUM_FALL  = 5;                // falling-edge sources
   localparam int NUM_EDGE  = NUM_RISE + NUM_FALL;
   localparam int ADDR_W    = 4;                // register address width

   // ****************************************************************
   // register offsets
   // ****************************************************************
   localparam logic [3:0] OFF_BUS_CONFIG = 4'h0;  // bus control config
   localparam logic [3:0] OFF_EDGE_ENS   = 4'h1;  // edge source enables
   localparam logic [3:0] OFF_FLAG_ONE   = 4'h2;  // edge flags, w1c
   localparam logic [3:0] OFF_IEN_ONE    = 4'h3;  // edge irq enables
   localparam logic [3:0] OFF_FLAG_TWO   = 4'h4;  // level flags (ro)
   localparam logic [3:0] OFF_IEN_TWO    = 4'h5;  // level irq enables
   localparam logic [3:0] OFF_EDGE_HI    = 4'h6;  // high nibbles of ens and ien
   localparam logic [3:0] OFF_FLAG_HI    = 4'h7;  // edge flags high, w1c

   // ****************************************************************
   // field positions and reset values
   // ****************************************************************
   localparam int          IRQ_PIN_SEL_POS = 6;              // config bit 6
   localparam logic [7:0]  BUS_CONFIG_RST  = 8'h00;
   localparam logic [11:0] EDGE_RST        = 12'h000;
   localparam logic [1:0]  LEVEL_RST       = 2'h0;

endpackage : ext_irq_pkg

// File: hdl/edge_one_shot.sv
// Purpose: synchronise a pin and emit one-cycle edge pulses
// Assumes: pin is asynchronous to clock
// Notes:   first stage feeds only the second stage
`timescale 1ns/10ps
module edge_one_shot (
   input  wire logic clock,    // system clock
   input  wire logic rst,      // sync reset, active high
   input  wire logic pin,      // raw pin level
   output logic      level,    // synchronised level
   output logic      rise,     // one-cycle 0->1 pulse
   output logic      fall      // one-cycle 1->0 pulse
);
   logic meta_reg;   // first synchroniser stage
   logic sync_reg;   // second stage
   logic prev_reg;   // previous synchronised level

   // ****************************************************************
   // two-flop synchroniser plus history
   // ****************************************************************
   always_ff @(posedge clock) begin
      if (rst) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
         prev_reg <= 1'b0;
      end else begin
         meta_reg <= pin;
         sync_reg <= meta_reg;
         prev_reg <= sync_reg;
      end
   end

   assign level = sync_reg;
   // pulses last one cycle, so a held level never re-fires
   assign rise  = sync_reg & ~prev_reg;
   assign fall  = ~sync_reg & prev_reg;
endmodule : edge_one_shot

// File: hdl/external_interrupt_inputs.sv
// Purpose: external interrupt inputs: edge, level and nonmaskable
// Assumes: pins asynchronous; registers on a plain strobe port
// Notes:   edge flags are write-one-to-clear; set beats clear
//
// Implementation choices: strobed register access and the placing of the registers.
`timescale 1ns/10ps
module external_interrupt_inputs (
   input  wire logic                           clock,            // 125 MHz
   input  wire logic                           rst,              // sync reset
   input  wire logic [ext_irq_pkg::NUM_RISE-1:0] rising_edge_irq_input,  // pins
   input  wire logic [ext_irq_pkg::NUM_FALL-1:0] falling_edge_irq_input, // pins
   input  wire logic                           level_irq_input_one_n,   // pin
   input  wire logic                           level_irq_input_two_n,   // pin
   input  wire logic                           nonmaskable_irq_input_n, // pin
   input  wire logic                           cpu_irq_disable,  // cpu I flag
   input  wire logic [ext_irq_pkg::ADDR_W-1:0]  addr,             // reg address
   input  wire logic [7:0]                     wdata,            // write data
   input  wire logic                           wr,               // write strobe
   input  wire logic                           rd,               // read strobe
   output logic      [7:0]                     rdata,            // read data
   output logic                                irq_req,          // maskable irq
   output logic                                nmi_req           // nmi pulse
);
   localparam int NE = ext_irq_pkg::NUM_EDGE;   // edge sources in total

   // ****************************************************************
   // state and wiring
   // ****************************************************************

   logic [7:0]    bus_control_config;          // config register
   logic [NE-1:0] edge_ens_reg;                // per-pin edge source enable
   logic [NE-1:0] flag_one_reg;                // edge flags
   logic [NE-1:0] ien_one_reg;                 // edge irq enables
   logic [1:0]    interrupt_enable_reg_two;    // level irq enables
   logic [1:0]    interrupt_flag_reg_two;      // level flags
   logic [NE-1:0] edge_pins;                   // all edge pins packed
   logic [NE-1:0] edge_hit;                    // detected active edges
   logic [NE-1:0] edge_rise;                   // rise pulses
   logic [NE-1:0] edge_fall;                   // fall pulses
   logic [1:0]    lvl_sync;                    // level pins synchronised
   logic          nmi_fall;                    // nmi falling pulse
   logic          irq_pin_select_bit;          // config bit 6
   logic [NE-1:0] flag_clr;                    // write-one-to-clear mask
   logic [7:0]    rdata_next;                  // read mux

   assign edge_pins          = {falling_edge_irq_input, rising_edge_irq_input};
   assign irq_pin_select_bit = bus_control_config[ext_irq_pkg::IRQ_PIN_SEL_POS];

   // ****************************************************************
   // pin conditioning
   // ****************************************************************
   genvar g;
   generate
      for (g = 0; g < NE; g++) begin : g_edge
         edge_one_shot u_os (
            .clock (clock),
            .rst   (rst),
            .pin   (edge_pins[g]),
            .level (),
            .rise  (edge_rise[g]),
            .fall  (edge_fall[g])
         );
         // the per-pin enable gates the pulse, so a disabled pin never flags
         // low indices rise-sensitive, high indices fall-sensitive
         if (g < ext_irq_pkg::NUM_RISE) begin : g_r
            assign edge_hit[g] = edge_rise[g] & edge_ens_reg[g];
         end else begin : g_f
            assign edge_hit[g] = edge_fall[g] & edge_ens_reg[g];
         end
      end
   endgenerate

   edge_one_shot u_lvl1 (
      .clock (clock),
      .rst   (rst),
      .pin   (level_irq_input_one_n),
      .level (lvl_sync[0]),
      .rise  (),
      .fall  ()
   );
   edge_one_shot u_lvl2 (
      .clock (clock),
      .rst   (rst),
      .pin   (level_irq_input_two_n),
      .level (lvl_sync[1]),
      .rise  (),
      .fall  ()
   );
   edge_one_shot u_nmi (
      .clock (clock),
      .rst   (rst),
      .pin   (nonmaskable_irq_input_n),
      .level (),
      .rise  (),
      .fall  (nmi_fall)
   );

   // ****************************************************************
   // configuration registers
   // ****************************************************************
   // config and enables written by software; reads have no side effects
   // a write to a read-only or unmapped offset simply falls through
   // the high nibbles share one offset, so a 12-bit field takes two writes
   // config and enables written by software
   always_ff @(posedge clock) begin
      if (rst) begin
         bus_control_config       <= ext_irq_pkg::BUS_CONFIG_RST;
         edge_ens_reg             <= ext_irq_pkg::EDGE_RST;
         ien_one_reg              <= ext_irq_pkg::EDGE_RST;
         interrupt_enable_reg_two <= ext_irq_pkg::LEVEL_RST;
      end else if (wr) begin
         unique case (addr)
            ext_irq_pkg::OFF_BUS_CONFIG: bus_control_config <= wdata;
            ext_irq_pkg::OFF_EDGE_ENS: begin
               edge_ens_reg[7:0] <= wdata;
            end
            ext_irq_pkg::OFF_IEN_ONE: begin
               ien_one_reg[7:0] <= wdata;
            end
            ext_irq_pkg::OFF_IEN_TWO: interrupt_enable_reg_two <= wdata[1:0];
            ext_irq_pkg::OFF_EDGE_HI: begin  // high nibbles of the 12-bit edge fields
               edge_ens_reg[11:8] <= wdata[3:0];
               ien_one_reg[11:8]  <= wdata[7:4];
            end
            default: ;  // unmapped or read-only: ignored
         endcase
      end
   end

   // ****************************************************************
   // edge flags
   // ****************************************************************
   // one place for the register write decode, shared by the clear paths
   function automatic logic reg_write_hit(
      input logic       we,    // write strobe
      input logic [3:0] a,     // bus address
      input logic [3:0] off    // register offset
   );
      return we && (a == off);
   endfunction : reg_write_hit

   // write-one-to-clear mask: low byte and high nibble at two offsets
   always_comb begin
      flag_clr = '0;
      if (reg_write_hit(wr, addr, ext_irq_pkg::OFF_FLAG_ONE)) begin
         flag_clr[7:0] = wdata;
      end
      if (reg_write_hit(wr, addr, ext_irq_pkg::OFF_FLAG_HI)) begin
         flag_clr[11:8] = wdata[3:0];
      end
   end

   // sticky until written one; a new edge wins over the clear
   always_ff @(posedge clock) begin
      if (rst) begin
         flag_one_reg <= ext_irq_pkg::EDGE_RST;
      end else begin
         // clear first, then or in new edges, so no edge is ever lost
         flag_one_reg <= (flag_one_reg & ~flag_clr) | edge_hit;
      end
   end

   // ****************************************************************
   // level flags follow the pins while selected
   // ****************************************************************
   // flags mirror the inverted synchronised pin, so software cannot clear
   // them; the source must release its pin to drop the request
   // deselected inputs read as clear whatever the pin does
   always_ff @(posedge clock) begin
      if (rst) begin
         interrupt_flag_reg_two <= ext_irq_pkg::LEVEL_RST;
      end else begin
         interrupt_flag_reg_two <= ~lvl_sync & {2{irq_pin_select_bit}};
      end
   end

   // ****************************************************************
   // request outputs
   // ****************************************************************
   // both requests are registered, so they never glitch toward the core
   // the disable flag only gates the maskable path; nmi bypasses it
   // nmi is a pulse: the core must latch it, the block keeps no state
   always_ff @(posedge clock) begin
      if (rst) begin
         irq_req <= 1'b0;
         nmi_req <= 1'b0;
      end else begin
         irq_req <= ~cpu_irq_disable &
                    (|(flag_one_reg & ien_one_reg) |
                     |(interrupt_flag_reg_two & interrupt_enable_reg_two));
         nmi_req <= nmi_fall & irq_pin_select_bit;
      end
   end

   // ****************************************************************
   // read port: data in the cycle after the strobe
   // ****************************************************************
   // reads never clear anything, so a polling loop is harmless
   // unmapped offsets return zero rather than stale bus contents
   always_comb begin
      rdata_next = 8'h00;
      unique case (addr)
         ext_irq_pkg::OFF_BUS_CONFIG: rdata_next = bus_control_config;
         ext_irq_pkg::OFF_EDGE_ENS:   rdata_next = edge_ens_reg[7:0];
         ext_irq_pkg::OFF_FLAG_ONE:   rdata_next = flag_one_reg[7:0];
         ext_irq_pkg::OFF_IEN_ONE:    rdata_next = ien_one_reg[7:0];
         ext_irq_pkg::OFF_FLAG_TWO:   rdata_next = {6'h00, interrupt_flag_reg_two};
         ext_irq_pkg::OFF_IEN_TWO:    rdata_next = {6'h00, interrupt_enable_reg_two};
         ext_irq_pkg::OFF_EDGE_HI:    rdata_next = {ien_one_reg[11:8], edge_ens_reg[11:8]};
         ext_irq_pkg::OFF_FLAG_HI:    rdata_next = {4'h0, flag_one_reg[11:8]};
         default:                     rdata_next = 8'h00;  // unmapped reads zero
      endcase
   end

   // data stands for one cycle per strobe cycle, zero otherwise
   always_ff @(posedge clock) begin
      if (rst) begin
         rdata <= 8'h00;
      end else begin
         rdata <= rd ? rdata_next : 8'h00;  // idle bus reads as zero
      end
   end
endmodule : external_interrupt_inputs

// File: test/ext_irq_checker_assertions.sv
// Purpose: port-level assertions for the external interrupt block
// Assumes: one clock, synchronous active-high reset
// Notes:   pin latency is a few cycles, so causes look back
`timescale 1ns/10ps
module ext_irq_checker (
   input wire logic       clock,                   // system clock
   input wire logic       rst,                     // sync reset
   input wire logic       nonmaskable_irq_input_n, // nmi pin
   input wire logic       cpu_irq_disable,         // cpu I flag
   input wire logic [3:0] addr,                    // reg address
   input wire logic       rd,                      // read strobe
   input wire logic [7:0] rdata,                   // read data
   input wire logic       irq_req,                 // maskable irq
   input wire logic       nmi_req                  // nmi pulse
);
   // ****************************************************
   // checks
   // ****************************************************
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   chk_reset_quiet: assert property (disable iff (1'b0) rst |=> !irq_req && !nmi_req && rdata == 8'h00)
      else $error("outputs not cleared by reset");
   chk_idle_rdata: assert property (!rd |=> rdata == 8'h00)
      else $error("read data without a read");
   chk_unmapped_zero: assert property (rd && addr[3] |=> rdata == 8'h00)
      else $error("unmapped read not zero");
   chk_mask_blocks: assert property (cpu_irq_disable |=> !irq_req)
      else $error("irq raised while disabled");
   chk_irq_cause: assert property ($rose(irq_req) |-> !$past(cpu_irq_disable))
      else $error("irq rose after disabled cycle");
   chk_nmi_pulse: assert property (nmi_req |=> !nmi_req)
      else $error("nmi longer than one cycle");
   chk_nmi_cause: assert property (nmi_req |-> !$past(nonmaskable_irq_input_n, 3))
      else $error("nmi without low pin");
   chk_nmi_quiet: assert property (nonmaskable_irq_input_n [*8] |-> !nmi_req)
      else $error("nmi while pin stayed high");
endmodule : ext_irq_checker

bind external_interrupt_inputs ext_irq_checker u_ext_irq_checker (.clock(clock), .rst(rst),
   .nonmaskable_irq_input_n(nonmaskable_irq_input_n), .cpu_irq_disable(cpu_irq_disable),
   .addr(addr), .rd(rd), .rdata(rdata), .irq_req(irq_req), .nmi_req(nmi_req));

// File: test/irq_source_model.sv
// Purpose: interrupt sources and processor side of the block
// Assumes: bench asks for pin levels; model moves after edges
// Notes:   pin map [6:0] rise, [11:7] fall, 12/13 level, 14 nmi
`timescale 1ns/10ps
module irq_source_model (
   input  wire logic        clock,   // system clock
   input  wire logic [14:0] want,    // wanted pin levels
   input  wire logic        mask,    // wanted cpu disable
   input  wire logic        nmi_req, // nmi pulse from block
   output logic      [14:0] pins,    // driven pin levels
   output logic             i_flag,  // cpu disable flag
   output int               nmi_cnt  // nmi pulses taken
);
   // pins change just after an edge, never on it
   always_ff @(posedge clock) begin
      pins   <= want;
      i_flag <= mask;
   end
   int taken = 0;   // pulses counted so far
   assign nmi_cnt = taken;
   // cpu takes every nmi pulse whatever its mask says
   always @(posedge clock) begin
      if (nmi_req === 1'b1) begin
         taken <= taken + 1;
      end
   end
endmodule : irq_source_model

// File: test/test_external_interrupt_inputs.sv
// Purpose: self-checking bench for the external interrupt block
// Assumes: 125 MHz clock, reset held 10 cycles
// Notes:   settle waits cover the pin synchroniser latency
`timescale 1ns/10ps
module test_external_interrupt_inputs;
   logic        clock = 1'b0;     // system clock
   logic        rst   = 1'b1;     // sync reset
   logic [3:0]  addr  = 4'h0;     // reg address
   logic [7:0]  wdata = 8'h00;    // write data
   logic        wr    = 1'b0;     // write strobe
   logic        rd    = 1'b0;     // read strobe
   logic        mask  = 1'b0;     // wanted cpu disable
   logic [14:0] want  = 15'h7F80; // idle: falling, level, nmi high
   logic [14:0] pins;             // pin levels
   logic        i_flag;           // cpu disable
   logic [7:0]  rdata;            // read data
   logic        irq_req;          // maskable irq
   logic        nmi_req;          // nmi pulse
   int          nmi_cnt;          // nmi pulses taken
   int          error_cnt = 0;    // mismatches
   int          checked   = 0;    // comparisons
   int          cycles    = 0;    // timeout counter
   always #4 clock = ~clock;
   irq_source_model u_irq_source_model (.clock(clock), .want(want), .mask(mask), .nmi_req(nmi_req),
      .pins(pins), .i_flag(i_flag), .nmi_cnt(nmi_cnt));
   external_interrupt_inputs u_external_interrupt_inputs (.clock(clock), .rst(rst),
      .rising_edge_irq_input(pins[6:0]), .falling_edge_irq_input(pins[11:7]),
      .level_irq_input_one_n(pins[12]), .level_irq_input_two_n(pins[13]),
      .nonmaskable_irq_input_n(pins[14]), .cpu_irq_disable(i_flag), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .irq_req(irq_req), .nmi_req(nmi_req));
   // ****************************************************
   // tasks
   // ****************************************************
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clock) begin addr <= a; wdata <= d; wr <= 1'b1; end
      @(posedge clock) wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
      @(posedge clock) begin addr <= a; rd <= 1'b1; end
      @(posedge clock) rd <= 1'b0;
      @(negedge clock) chk(rdata, exp);
   endtask : rd_chk
   // new pin levels, then wait out synchroniser and flag
   task automatic drive(input logic [14:0] v);
      @(posedge clock) want <= v;
      repeat (10) @(posedge clock);
   endtask : drive
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : test_done
   // hang guard, far above the expected run length
   always @(posedge clock) begin
      cycles++;
      if (cycles == 5000) begin error_cnt++; test_done(); end
   end
   // ****************************************************
   // tests
   // ****************************************************
   initial begin
      repeat (10) @(posedge clock);
      rst <= 1'b0;
      for (int a = 0; a < 16; a++) rd_chk(a[3:0], 8'h00);
      $display("test reset done");
      drive(15'h707F);                       // edges while sources off
      rd_chk(4'h2, 8'h00);
      rd_chk(4'h7, 8'h00);
      drive(15'h7F80);
      wr_reg(4'h1, 8'hFF);
      wr_reg(4'h6, 8'h0F);
      drive(15'h7FFF);
      rd_chk(4'h2, 8'h7F);
      wr_reg(4'h2, 8'hFF);                   // clear while pins stay high
      rd_chk(4'h2, 8'h00);
      drive(15'h7F80);
      rd_chk(4'h2, 8'h00);
      drive(15'h7000);
      rd_chk(4'h2, 8'h80);
      rd_chk(4'h7, 8'h0F);
      chk({7'h00, irq_req}, 8'h00);
      drive(15'h7F80);
      rd_chk(4'h7, 8'h0F);
      wr_reg(4'h3, 8'hFF);
      wr_reg(4'h6, 8'hFF);
      drive(15'h7F80);
      chk({7'h00, irq_req}, 8'h01);
      mask <= 1'b1;
      drive(15'h7F80);
      chk({7'h00, irq_req}, 8'h00);
      mask <= 1'b0;
      wr_reg(4'h2, 8'hFF);
      wr_reg(4'h7, 8'h0F);
      drive(15'h7F80);
      rd_chk(4'h7, 8'h00);
      chk({7'h00, irq_req}, 8'h00);
      $display("test edge done");
      drive(15'h0F80);                       // level and nmi low, bit 6 clear
      rd_chk(4'h4, 8'h00);
      chk(nmi_cnt[7:0], 8'h00);
      drive(15'h7F80);
      wr_reg(4'h0, 8'h40);
      wr_reg(4'h5, 8'h01);
      drive(15'h4F80);
      wr_reg(4'h4, 8'hFF);                   // read-only flags ignore writes
      rd_chk(4'h4, 8'h03);
      chk({7'h00, irq_req}, 8'h01);
      drive(15'h5F80);
      rd_chk(4'h4, 8'h02);
      chk({7'h00, irq_req}, 8'h00);
      $display("test level done");
      mask <= 1'b1;
      drive(15'h3F80);
      chk(nmi_cnt[7:0], 8'h01);
      drive(15'h3F80);
      chk(nmi_cnt[7:0], 8'h01);
      drive(15'h7F80);
      drive(15'h3F80);
      chk(nmi_cnt[7:0], 8'h02);
      $display("test nmi done");
      rst <= 1'b1;                           // second reset in mid-run
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      rd_chk(4'h0, 8'h00);
      rd_chk(4'h1, 8'h00);
      rd_chk(4'h3, 8'h00);
      rd_chk(4'h4, 8'h00);
      rd_chk(4'h5, 8'h00);
      rd_chk(4'h6, 8'h00);
      chk({7'h00, irq_req}, 8'h00);
      $display("test reset again done");
      test_done();
   end
endmodule : test_external_interrupt_inputs
